// File: src/vid_ctl_params.svh
// Purpose: Offsets, field positions, reset values and codes for the video output controls.
// Assumes: Eight-bit registers reached by sub-address over the serial control port.
// Notes:   Definitions only.
`ifndef VID_CTL_PARAMS_SVH
`define VID_CTL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define OUT_PIN_CTRL_ADDR     8'h02
`define DEC_TUNE_CTRL_ADDR    8'h03
`define OUT_PIN_CTRL_RESET    8'h00
`define DEC_TUNE_CTRL_RESET   8'h00

// ----------------------------------------------------------------------------
// Output pin control fields
// ----------------------------------------------------------------------------
`define LINE_POL_BIT          0
`define FRAME_POL_BIT         1
`define VALID_POL_BIT         2
`define CLK_FLIP_BIT          3
`define SYNC_EMB_BIT          4
`define VALID_EMB_BIT         5
`define FILL_LSB              6

// ----------------------------------------------------------------------------
// Decode tuning fields
// ----------------------------------------------------------------------------
`define SPLIT_BIT             0
`define KILL_LSB              1
`define CORE_LSB              3
`define SPEED_BIT             5
`define VPIN_BIT              6

// ----------------------------------------------------------------------------
// Fill levels (eight-bit luma / chroma)
// ----------------------------------------------------------------------------
`define BLACK_Y               8'h10
`define BLACK_C               8'h80
`define BLUE_Y                8'h29
`define BLUE_CB               8'hF0
`define BLUE_CR               8'h6E

// ----------------------------------------------------------------------------
// Coring dead bands in LSB
// ----------------------------------------------------------------------------
`define CORE_BAND0            3'h2
`define CORE_BAND1            3'h3
`define CORE_BAND2            3'h4
`define CORE_NONE             3'h0

`endif

// File: src/vid_ctl_pkg.sv
// Purpose: Types shared by the video output control logic.
// Assumes: Field codes as held in vid_ctl_params.svh.
// Notes:   Types only.
package vid_ctl_pkg;

    // ------------------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        IF_CAMERA      = 2'b00,
        IF_CAMERA_EMB  = 2'b01,
        IF_SYNC_PINS   = 2'b10,
        IF_EMB_656     = 2'b11
    } out_if_e;

    typedef enum logic [1:0] {
        FILL_BLACK   = 2'b00,
        FILL_BLUE    = 2'b01,
        FILL_PASS    = 2'b10,
        FILL_RESV    = 2'b11
    } fill_e;

    // Raw timing from the decoder core, active high.
    typedef struct packed {
        logic line_sync;
        logic frame_sync;
        logic valid;
        logic vert_active;
        logic field_id;
        logic line_start;
    } timing_s;

    // Pixel sample.
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } pixel_s;

    // Settings presented to decoder core.
    typedef struct packed {
        logic       use_2d_chroma;
        logic       chroma_kill;
        logic [2:0] core_band;
        logic       gain_slow;
    } tune_s;

endpackage : vid_ctl_pkg

// File: src/reg_pair.sv
// Purpose: Two eight-bit registers written by sub-address with registered read data.
// Assumes: One write strobe per access, synchronous to mclk.
// Notes:   Unmapped sub-addresses read as zero and ignore writes.
`timescale 1ns/1ps
`include "vid_ctl_params.svh"
module reg_pair import vid_ctl_pkg::*; (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata_q,
    output logic      [7:0] pin_ctrl_q,
    output logic      [7:0] tune_ctrl_q
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    // Every bit is stored as written, reserved top bit of tuning included.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_ctrl_q  <= `OUT_PIN_CTRL_RESET;
            tune_ctrl_q <= `DEC_TUNE_CTRL_RESET;
        end else if (wr_en) begin
            if (addr == `OUT_PIN_CTRL_ADDR) begin
                pin_ctrl_q <= wdata;
            end
            if (addr == `DEC_TUNE_CTRL_ADDR) begin
                tune_ctrl_q <= wdata;
            end
        end
    end

    // Read data registered so the serial port sees a stable byte.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            unique case (addr)
                `OUT_PIN_CTRL_ADDR:  rdata_q <= pin_ctrl_q;
                `DEC_TUNE_CTRL_ADDR: rdata_q <= tune_ctrl_q;
                default:             rdata_q <= 8'h00;
            endcase
        end
    end

endmodule : reg_pair

// File: src/vid_out_ctl.sv
// Purpose: Output pin and decode tuning control of the composite video decoder.
// Assumes: Register writes and decoder timing arrive synchronous to mclk (20 MHz).
// Notes:   Settings apply at the next line start so a line never changes mid-way.
// What this block does
// - Line sync pin active low when its polarity bit is 0, high when 1.
// - Frame sync pin active low when its polarity bit is 0, high when 1.
// - Pixel valid pin active low when its polarity bit is 0, high when 1.
// - Clock flip bit 0: sample on rising edge; 1: on falling edge.
// - Embedded modes: sync pins low unless sync-in-embedded bit is 1.
// - Embedded modes: valid pin low unless valid-in-embedded bit is 1.
// - No signal: fill 00 gives black, 01 gives blue, 11 reserved.
// - Fill code 10 passes decoded input through during signal loss.
// - NTSC small or rotated sizes: split bit picks primary or 2D chroma.
// - Other input and size combinations ignore the split bit.
// - Kill code 01 kills chroma when colour loop loses lock.
// - Kill code 10 kills chroma when burst drops below about -23 dB.
// - Kill code 00 kills on either condition; code 11 reserved.
// - Coring codes 00,01,10 give 2,3,4 LSB bands; 11 gives none.
// - Speed bit 0 makes gain loops quick, 1 makes them slow.
// - Vertical pin carries frame sync when function bit 0, field when 1.
// - Camera mode vertical pin always carries vertical active flag.
// - Interface codes 01 and 11 are embedded modes, sync pins low unless sync-in-embedded bit is 1.
// - No-signal flag from loss of both locks, or vertical only, by define bit.
`timescale 1ns/1ps
`include "vid_ctl_params.svh"
module vid_out_ctl import vid_ctl_pkg::*; (
    input  wire logic       mclk,
    input  wire logic       rst,
    // Register access port from the serial control slave.
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Mode from the neighbouring control registers.
    input  wire logic [1:0] output_interface_select,
    input  wire logic       ntsc_input,
    input  wire logic       small_size,
    input  wire logic       no_signal_on_vert_only,
    // Decoder status.
    input  wire logic       h_lock_lost,
    input  wire logic       v_lock_lost,
    input  wire logic       colour_pll_unlocked,
    input  wire logic       burst_low,
    // Decoder timing and pixels.
    input  wire timing_s    timing,
    input  wire pixel_s     pixel_in,
    // Pins and status toward the capture port.
    output logic            line_sync_out,
    output logic            frame_sync_out,
    output logic            pixel_valid_out,
    output logic            pixel_clock_out,
    output logic            no_signal_flag,
    output pixel_s          pixel_out,
    // Settings back to the decoder core.
    output tune_s           tune_out
);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0] pin_ctrl_q;
    logic [7:0] tune_ctrl_q;
    logic [7:0] pin_live_q;
    logic [7:0] tune_live_q;
    logic       clk_div_q;

    reg_pair u_regs (
        .mclk        (mclk),
        .rst         (rst),
        .wr_en       (reg_wr_en),
        .addr        (reg_addr),
        .wdata       (reg_wdata),
        .rdata_q     (reg_rdata),
        .pin_ctrl_q  (pin_ctrl_q),
        .tune_ctrl_q (tune_ctrl_q)
    );

    // ------------------------------------------------------------------------
    // Line-aligned shadow
    // ------------------------------------------------------------------------
    // Copying at line start keeps a half-line from showing two polarities.
    // Apply at line start.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_live_q  <= `OUT_PIN_CTRL_RESET;
            tune_live_q <= `DEC_TUNE_CTRL_RESET;
        end else if (timing.line_start) begin
            pin_live_q  <= pin_ctrl_q;
            tune_live_q <= tune_ctrl_q;
        end
    end

    // ------------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------------
    logic    line_pol;
    logic    frame_pol;
    logic    valid_pol;
    logic    clk_flip;
    logic    sync_emb;
    logic    valid_emb;
    fill_e   fill_mode;
    out_if_e if_mode;
    logic    embedded;
    logic    nosig;

    assign line_pol  = pin_live_q[`LINE_POL_BIT];
    assign frame_pol = pin_live_q[`FRAME_POL_BIT];
    assign valid_pol = pin_live_q[`VALID_POL_BIT];
    assign clk_flip  = pin_live_q[`CLK_FLIP_BIT];
    assign sync_emb  = pin_live_q[`SYNC_EMB_BIT];
    assign valid_emb = pin_live_q[`VALID_EMB_BIT];
    assign fill_mode = fill_e'(pin_live_q[`FILL_LSB +: 2]);
    assign if_mode   = out_if_e'(output_interface_select);

    assign embedded = (if_mode == IF_CAMERA_EMB) || (if_mode == IF_EMB_656);

    assign nosig = no_signal_on_vert_only ? v_lock_lost : (h_lock_lost && v_lock_lost);

    // ------------------------------------------------------------------------
    // Sync and valid pins
    // ------------------------------------------------------------------------
    logic line_act;
    logic vert_act;
    logic valid_act;
    logic vert_src;

    // Vertical pin source selection.
    always_comb begin
        if (if_mode == IF_CAMERA || if_mode == IF_CAMERA_EMB) begin
            vert_src = timing.vert_active;
        end else if (tune_live_q[`VPIN_BIT]) begin
            vert_src = timing.field_id;
        end else begin
            vert_src = timing.frame_sync;
        end
    end

    // Gating in embedded modes: the pin is held low, not at inactive level.
    always_comb begin
        line_act  = timing.line_sync;
        vert_act  = vert_src;
        valid_act = timing.valid;
    end

    // Pins come straight from flip-flops.
    always_ff @(posedge mclk) begin
        if (rst) begin
            line_sync_out   <= 1'b0;
            frame_sync_out  <= 1'b0;
            pixel_valid_out <= 1'b0;
        end else begin
            if (embedded && !sync_emb) begin
                line_sync_out  <= 1'b0;
                frame_sync_out <= 1'b0;
            end else begin
                line_sync_out  <= line_pol ? line_act : ~line_act;
                frame_sync_out <= frame_pol ? vert_act : ~vert_act;
            end
            if (embedded && !valid_emb) begin
                pixel_valid_out <= 1'b0;
            end else begin
                pixel_valid_out <= valid_pol ? valid_act : ~valid_act;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pixel clock
    // ------------------------------------------------------------------------
    // Data changes when the divider is low-to-high internally; a normal clock
    // rises mid-data, flipping moves the capture edge to the falling edge.
    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_div_q <= 1'b0;
        end else begin
            clk_div_q <= ~clk_div_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pixel_clock_out <= 1'b0;
        end else begin
            pixel_clock_out <= clk_div_q ^ clk_flip;
        end
    end

    // ------------------------------------------------------------------------
    // No-signal fill
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            no_signal_flag <= 1'b0;
            pixel_out      <= '0;
        end else begin
            no_signal_flag <= nosig;
            if (!nosig) begin
                pixel_out <= pixel_in;
            end else begin
                unique case (fill_mode)
                    FILL_BLACK: pixel_out <= '{y: `BLACK_Y, cb: `BLACK_C, cr: `BLACK_C};
                    FILL_BLUE:  pixel_out <= '{y: `BLUE_Y, cb: `BLUE_CB, cr: `BLUE_CR};
                    FILL_PASS:  pixel_out <= pixel_in;
                    // Reserved code falls back to black so the picture stays defined.
                    FILL_RESV:  pixel_out <= '{y: `BLACK_Y, cb: `BLACK_C, cr: `BLACK_C};
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Decode tuning
    // ------------------------------------------------------------------------
    logic [1:0] kill_code;
    logic [1:0] core_code;
    assign kill_code = tune_live_q[`KILL_LSB +: 2];
    assign core_code = tune_live_q[`CORE_LSB +: 2];

    always_ff @(posedge mclk) begin
        if (rst) begin
            tune_out <= '0;
        end else begin
            tune_out.use_2d_chroma <= ntsc_input && small_size && tune_live_q[`SPLIT_BIT];
            unique case (kill_code)
                2'b00: tune_out.chroma_kill <= colour_pll_unlocked || burst_low;
                2'b01: tune_out.chroma_kill <= colour_pll_unlocked;
                2'b10: tune_out.chroma_kill <= burst_low;
                2'b11: tune_out.chroma_kill <= colour_pll_unlocked || burst_low;
            endcase
            unique case (core_code)
                2'b00: tune_out.core_band <= `CORE_BAND0;
                2'b01: tune_out.core_band <= `CORE_BAND1;
                2'b10: tune_out.core_band <= `CORE_BAND2;
                2'b11: tune_out.core_band <= `CORE_NONE;
            endcase
            tune_out.gain_slow <= tune_live_q[`SPEED_BIT];
        end
    end

endmodule : vid_out_ctl

// File: bench/vid_out_ctl_props.sv
// Purpose: Port checker for vid_out_ctl.
// Assumes: Settings go live one cycle after a line_start pulse.
// Notes:   Keeps its own copy of the stored and live settings.
`timescale 1ns/1ps
module vid_out_ctl_props import vid_ctl_pkg::*; (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] output_interface_select,
    input wire logic       ntsc_input,
    input wire logic       small_size,
    input wire logic       no_signal_on_vert_only,
    input wire logic       h_lock_lost,
    input wire logic       v_lock_lost,
    input wire logic       colour_pll_unlocked,
    input wire logic       burst_low,
    input wire timing_s    timing,
    input wire pixel_s     pixel_in,
    input wire logic       line_sync_out,
    input wire logic       frame_sync_out,
    input wire logic       pixel_valid_out,
    input wire logic       no_signal_flag,
    input wire pixel_s     pixel_out,
    input wire tune_s      tune_out
);
    logic [7:0] p_q;
    logic [7:0] t_q;
    logic [7:0] lp_q;
    logic [7:0] lt_q;

    // Stored registers; other addresses are ignored.
    always_ff @(posedge mclk) begin
        if (rst) begin
            p_q <= 8'h00;
            t_q <= 8'h00;
        end else if (reg_wr_en && reg_addr == 8'h02) begin
            p_q <= reg_wdata;
        end else if (reg_wr_en && reg_addr == 8'h03) begin
            t_q <= reg_wdata;
        end
    end

    // Live copy, so a line never changes half-way.
    always_ff @(posedge mclk) begin
        if (rst) begin
            lp_q <= 8'h00;
            lt_q <= 8'h00;
        end else if (timing.line_start) begin
            lp_q <= p_q;
            lt_q <= t_q;
        end
    end

    // Expected pin and setting values from the live copy.
    wire       emb  = output_interface_select[0];
    wire       fsrc = !output_interface_select[1] ? timing.vert_active
                    : (lt_q[6] ? timing.field_id : timing.frame_sync);
    wire       ls_e = (emb && !lp_q[4]) ? 1'b0 : timing.line_sync ^ !lp_q[0];
    wire       fs_e = (emb && !lp_q[4]) ? 1'b0 : fsrc ^ !lp_q[1];
    wire       dv_e = (emb && !lp_q[5]) ? 1'b0 : timing.valid ^ !lp_q[2];
    wire       ns_e = v_lock_lost && (h_lock_lost || no_signal_on_vert_only);
    wire       ck_e = (lt_q[2:1] == 2'b01) ? colour_pll_unlocked
                    : (lt_q[2:1] == 2'b10) ? burst_low : colour_pll_unlocked || burst_low;
    wire [2:0] cb_e = (lt_q[4:3] == 2'b11) ? 3'h0 : {1'b0, lt_q[4:3]} + 3'h2;
    wire [7:0] rd_e = (reg_addr == 8'h02) ? p_q : (reg_addr == 8'h03) ? t_q : 8'h00;

    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);

    AST_LINE_POL: assert property (!$past(rst) |-> line_sync_out == $past(ls_e))
        else $error("line sync pin wrong");
    AST_FRAME_PIN: assert property (!$past(rst) |-> frame_sync_out == $past(fs_e))
        else $error("frame sync pin wrong");
    AST_VALID_POL: assert property (!$past(rst) |-> pixel_valid_out == $past(dv_e))
        else $error("valid pin wrong");
    AST_SYNC_EMB: assert property (!$past(rst) && $past(emb && !lp_q[4])
        |-> !line_sync_out && !frame_sync_out) else $error("sync pins not low");
    AST_VALID_EMB: assert property (!$past(rst) && $past(emb && !lp_q[5])
        |-> !pixel_valid_out) else $error("valid pin not low");
    AST_NO_SIG: assert property (!$past(rst) |-> no_signal_flag == $past(ns_e))
        else $error("no signal flag wrong");
    AST_KILL: assert property (!$past(rst) |-> tune_out.chroma_kill == $past(ck_e))
        else $error("chroma kill wrong");
    AST_CORE: assert property (!$past(rst) |-> tune_out.core_band == $past(cb_e))
        else $error("coring band wrong");
    AST_SPEED: assert property (!$past(rst) |-> tune_out.gain_slow == $past(lt_q[5]))
        else $error("gain speed wrong");
    AST_SPLIT: assert property (!$past(rst) |-> tune_out.use_2d_chroma
        == $past(lt_q[0] && ntsc_input && small_size)) else $error("split wrong");
    AST_READ: assert property (!$past(rst) |-> reg_rdata == $past(rd_e))
        else $error("read data wrong");
    AST_PASS: assert property (!$past(rst) && $past(lp_q[7:6]) == 2'b10
        |-> pixel_out == $past(pixel_in)) else $error("pass through wrong");
endmodule : vid_out_ctl_props

bind vid_out_ctl vid_out_ctl_props u_vid_out_ctl_props (
    .mclk, .rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .output_interface_select,
    .ntsc_input, .small_size, .no_signal_on_vert_only, .h_lock_lost, .v_lock_lost,
    .colour_pll_unlocked, .burst_low, .timing, .pixel_in, .line_sync_out, .frame_sync_out,
    .pixel_valid_out, .no_signal_flag, .pixel_out, .tune_out
);

// File: bench/capture_sink.sv
// Purpose: Capture port model that takes a pixel on its capture edge.
// Assumes: The pixel clock pin changes only on mclk edges.
// Notes:   flip mirrors the clock phase bit the bench last wrote.
`timescale 1ns/1ps
module capture_sink import vid_ctl_pkg::*; (
    input  wire logic   mclk,
    input  wire logic   flip,
    input  wire logic   pclk,
    input  wire pixel_s pix,
    output pixel_s      got_q
);
    logic pclk_q;

    always_ff @(posedge mclk) begin
        pclk_q <= pclk;
        if (pclk != pclk_q && pclk == !flip) begin
            got_q <= pix;
        end
    end
endmodule : capture_sink

// File: bench/tb.sv
// Purpose: Self-checking bench for vid_out_ctl.
// Assumes: Settings go live after the next line_start pulse.
// Notes:   small_size stays high until the last split check, so the others lean on ntsc_input.
`timescale 1ns/1ps
module tb import vid_ctl_pkg::*; ;
    logic        mclk, rst, reg_wr_en, ntsc_input, small_size, no_signal_on_vert_only, flip;
    logic        h_lock_lost, v_lock_lost, colour_pll_unlocked, burst_low, no_signal_flag;
    logic        line_sync_out, frame_sync_out, pixel_valid_out, pixel_clock_out;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [1:0]  output_interface_select;
    logic [23:0] fx [4] = '{24'h108080, 24'h29F06E, 24'h123456, 24'h108080};
    timing_s     timing;
    pixel_s      pixel_in, pixel_out, got;
    tune_s       tune_out;
    int          n_fail, checks;

    vid_out_ctl u_vid_out_ctl (
        .mclk, .rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .output_interface_select,
        .ntsc_input, .small_size, .no_signal_on_vert_only, .h_lock_lost, .v_lock_lost,
        .colour_pll_unlocked, .burst_low, .timing, .pixel_in, .line_sync_out, .frame_sync_out,
        .pixel_valid_out, .pixel_clock_out, .no_signal_flag, .pixel_out, .tune_out
    );
    capture_sink u_capture_sink (
        .mclk, .flip, .pclk(pixel_clock_out), .pix(pixel_out), .got_q(got)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        repeat (2) @(posedge mclk);
        #1 chk(reg_rdata, e);
    endtask : rd

    // One line_start pulse, then room for the live copy to reach the pins.
    task automatic line();
        @(posedge mclk);
        timing.line_start <= 1'b1;
        @(posedge mclk);
        timing.line_start <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : line

    // Raw timing as {line, frame, valid, vert active, field}.
    task automatic raw(input logic [1:0] m, input logic [4:0] v);
        @(posedge mclk);
        output_interface_select <= m;
        timing[5:1] <= v;
        repeat (2) @(posedge mclk);
        #1;
    endtask : raw

    // Lock status as {vertical only, line lost, frame lost}.
    task automatic lock(input logic [2:0] s);
        @(posedge mclk);
        {no_signal_on_vert_only, h_lock_lost, v_lock_lost} <= s;
        repeat (3) @(posedge mclk);
        #1;
    endtask : lock

    task automatic t_regs();
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        wr(8'h03, 8'hA5);
        rd(8'h03, 8'hA5);
    endtask : t_regs

    task automatic t_pol();
        logic [2:0] q;
        q = 3'h0;
        for (int i = 0; i < 8; i++) begin
            wr(8'h02, {5'h00, i[2:0]});
            raw(2'b10, 5'h1C);
            chk({pixel_valid_out, frame_sync_out, line_sync_out}, q);
            line();
            chk({pixel_valid_out, frame_sync_out, line_sync_out}, i[2:0]);
            raw(2'b10, 5'h00);
            chk({pixel_valid_out, frame_sync_out, line_sync_out}, i[2:0] ^ 3'h7);
            q = i[2:0];
        end
        wr(8'h03, 8'h40);
        line();
        raw(2'b10, 5'h08);
        chk(frame_sync_out, 1'b0);
        raw(2'b10, 5'h01);
        chk(frame_sync_out, 1'b1);
        raw(2'b00, 5'h02);
        chk(frame_sync_out, 1'b1);
        raw(2'b00, 5'h01);
        chk(frame_sync_out, 1'b0);
    endtask : t_pol

    task automatic t_emb();
        wr(8'h02, 8'h07);
        line();
        raw(2'b01, 5'h1F);
        chk({line_sync_out, frame_sync_out, pixel_valid_out}, 3'h0);
        raw(2'b11, 5'h1F);
        chk({line_sync_out, frame_sync_out, pixel_valid_out}, 3'h0);
        wr(8'h02, 8'h37);
        line();
        chk({line_sync_out, frame_sync_out, pixel_valid_out}, 3'h7);
        wr(8'h02, 8'h27);
        line();
        chk({line_sync_out, frame_sync_out, pixel_valid_out}, 3'h1);
    endtask : t_emb

    task automatic t_fill();
        lock(3'b001);
        chk(no_signal_flag, 1'b0);
        chk(pixel_out, 24'h123456);
        lock(3'b101);
        chk(no_signal_flag, 1'b1);
        lock(3'b010);
        chk(no_signal_flag, 1'b0);
        lock(3'b011);
        chk(no_signal_flag, 1'b1);
        for (int c = 0; c < 4; c++) begin
            wr(8'h02, {c[1:0], 6'h00});
            line();
            chk(pixel_out, fx[c]);
        end
    endtask : t_fill

    task automatic t_tune();
        logic [7:0] v;
        logic       kx;
        for (int k = 0; k < 16; k++) begin
            v = {2'b10, k[0], k[3:2], k[3:2], k[1]};
            kx = (k[3:2] == 2'b01) ? k[1] : (k[3:2] == 2'b10) ? k[0] : (k[1] | k[0]);
            wr(8'h03, v);
            @(posedge mclk);
            {colour_pll_unlocked, burst_low, ntsc_input} <= {k[1:0], k[0]};
            line();
            chk(tune_out.chroma_kill, kx);
            chk(tune_out.core_band, k[3:2] == 2'b11 ? 3'h0 : {1'b0, k[3:2]} + 3'h2);
            chk(tune_out.gain_slow, k[0]);
            chk(tune_out.use_2d_chroma, k[1] & k[0]);
            rd(8'h03, v);
        end
        // Split bit is still set with NTSC input; a full-size picture must ignore it.
        @(posedge mclk);
        small_size <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(tune_out.use_2d_chroma, 1'b0);
    endtask : t_tune

    task automatic t_clk();
        logic pc;
        lock(3'b000);
        for (int f = 0; f < 2; f++) begin
            @(posedge mclk);
            flip     <= f[0];
            pixel_in <= f[0] ? 24'h5A3C1E : 24'hA5C3E1;
            wr(8'h02, {4'h0, f[0], 3'h7});
            line();
            repeat (4) @(posedge mclk);
            #1 chk(got, f[0] ? 24'h5A3C1E : 24'hA5C3E1);
            pc = pixel_clock_out;
            @(posedge mclk);
            #1 chk(pixel_clock_out, !pc);
        end
    endtask : t_clk

    initial begin
        rst = 1'b1;
        {reg_wr_en, ntsc_input, no_signal_on_vert_only, flip} = 4'h0;
        {h_lock_lost, v_lock_lost, colour_pll_unlocked, burst_low} = 4'h0;
        {reg_addr, reg_wdata, output_interface_select} = 18'h00000;
        small_size = 1'b1;
        timing = '0;
        pixel_in = 24'h123456;
        n_fail = 0;
        checks = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_pol();
        t_emb();
        t_fill();
        t_tune();
        t_clk();
        stop_test();
    end

    // Cut a hang short and report it as a failure.
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        stop_test();
    end
endmodule : tb
